// ===== design/ict_i2c_tuning.sv
// i2c port tuning: input filter and hold, sda output delay, bus watchdog,
// sequence error flag and the second i2c control register
// assumes a 200 MHz core clock and a link clock from the control channel
module ict_i2c_tuning
    import ict_pkg::*;
#(
    parameter logic [`ICT_WD_W-1:0] WD_FAST_CYC = `ICT_WD_W'(`ICT_WD_FAST_CYC),
    parameter logic [`ICT_WD_W-1:0] WD_SLOW_CYC = `ICT_WD_W'(`ICT_WD_SLOW_CYC)
) (
    // clocks and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       linkClk,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regWrRemote,
    input  wire logic       regRd,
    output logic [7:0]      regRdData,
    // control channel events and remote slave traffic
    input  wire logic       seqErrLink,
    input  wire logic       slaveWrIn,
    output logic            slaveWrOut,
    // i2c pins
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // core side of the i2c port
    input  wire logic       sdaLowReq,
    output logic            sclSample,
    output logic            sdaSample,
    output logic            busFree
);
    ict_main_s st;
    ict_main_s next_st;
    ict_link_s lk;
    ict_link_s next_lk;
    logic                   sclF;
    logic                   sdaF;
    logic                   seqEvent;
    logic                   wrLocal;
    logic                   clrPulse;
    logic                   activity;
    logic                   wdOff;
    logic                   sdaWant;
    logic [2:0]             hold;
    logic [`ICT_DLY_W-1:0]  dlyTarget;
    logic [`ICT_WD_W-1:0]   wdLimit;

    // tap of the hold line for a hold code
    function automatic logic [6:0] holdTap(input logic [2:0] code);
        holdTap = 7'(code * `ICT_HOLD_STEP_CYC - 1);
    endfunction

    // sda output delay in cycles for a delay code
    function automatic logic [`ICT_DLY_W-1:0] sdaDelay(input logic [1:0] code);
        sdaDelay = `ICT_DLY_W'(`ICT_SDA_BASE_CYC + code * `ICT_SDA_STEP_CYC);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // input filters
    ict_glitch_filter u_sclFilter (
        .clock (clock),
        .rst_n (rst_n),
        .depth (st.timing[`ICT_TM_FILT_HI:`ICT_TM_FILT_LO]),
        .pinIn (sclIn),
        .level (sclF)
    );

    ict_glitch_filter u_sdaFilter (
        .clock (clock),
        .rst_n (rst_n),
        .depth (st.timing[`ICT_TM_FILT_HI:`ICT_TM_FILT_LO]),
        .pinIn (sdaIn),
        .level (sdaF)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side: each error pulse flips a toggle
    always_comb begin
        next_lk     = lk;
        next_lk.tgl = lk.tgl ^ seqErrLink;
    end

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core side next state
    always_comb begin
        next_st   = st;
        hold      = st.timing[`ICT_TM_HOLD_HI:`ICT_TM_HOLD_LO];
        dlyTarget = sdaDelay(st.ctrl2[`ICT_C2_DLY_HI:`ICT_C2_DLY_LO]);
        wdLimit   = st.ctrl2[`ICT_C2_SPEEDUP] ? WD_FAST_CYC : WD_SLOW_CYC;
        wdOff     = st.ctrl2[`ICT_C2_WDOFF];
        activity  = (sclF != st.sclPrev) || (sdaF != st.sdaPrev);
        sdaWant   = sdaLowReq;

        // toggle crossing, event once second and third stage agree
        next_st.tgS1 = lk.tgl;
        next_st.tgS2 = st.tgS1;
        next_st.tgS3 = st.tgS2;
        seqEvent     = (st.tgS2 == st.tgS3) && (st.tgS3 != st.tgSeen);
        if (seqEvent) begin
            next_st.tgSeen = st.tgS3;
        end

        // register writes; remote writes dropped while locked
        wrLocal  = regWr && !(regWrRemote && st.ctrl2[`ICT_C2_LWBLOCK]);
        clrPulse = wrLocal && (regAddr == `ICT_REG_CTRL2) && regWrData[`ICT_C2_CLEAR];
        if (wrLocal && (regAddr == `ICT_REG_CTRL2)) begin
            next_st.ctrl2 = (regWrData & `ICT_CTRL2_WMASK) | (st.ctrl2 & ~`ICT_CTRL2_WMASK);
        end
        if (wrLocal && (regAddr == `ICT_REG_TIMING)) begin
            next_st.timing = regWrData & `ICT_TIMING_WMASK;
        end
        if (clrPulse) begin
            next_st.ctrl2[`ICT_C2_SEQERR] = 1'b0;
        end
        if (seqEvent) begin
            next_st.ctrl2[`ICT_C2_SEQERR] = 1'b1;
        end

        // register reads
        if (regRd) begin
            if (regAddr == `ICT_REG_CTRL2) begin
                next_st.rdData = st.ctrl2;
            end else if (regAddr == `ICT_REG_TIMING) begin
                next_st.rdData = st.timing;
            end else begin
                next_st.rdData = `ICT_RD_UNMAPPED;
            end
        end

        // sda hold line, scl passes one flop
        next_st.holdLine  = {st.holdLine[`ICT_LINE_W-2:0], sdaF};
        next_st.sclSample = sclF;
        next_st.sdaSample = (hold == 3'h0) ? sdaF : st.holdLine[holdTap(hold)];

        // sda output follows the request after the programmed delay
        if (sdaWant == st.sdaOe) begin
            next_st.dlyCnt = '0;
        end else if (st.dlyCnt == dlyTarget - `ICT_DLY_W'(1)) begin
            next_st.sdaOe  = sdaWant;
            next_st.dlyCnt = '0;
        end else begin
            next_st.dlyCnt = st.dlyCnt + `ICT_DLY_W'(1);
        end

        // bus watchdog
        next_st.sclPrev = sclF;
        next_st.sdaPrev = sdaF;
        if (wdOff) begin
            next_st.wdState = ICT_WD_RUN;
            next_st.idleCnt = '0;
            next_st.busFree = 1'b0;
            next_st.sclOe   = 1'b0;
        end else begin
            unique case (st.wdState)
                ICT_WD_RUN: begin
                    if (activity) begin
                        next_st.idleCnt = '0;
                        next_st.busFree = 1'b0;
                    end else if (st.busFree) begin
                        next_st.idleCnt = '0;
                    end else if (st.idleCnt == wdLimit - `ICT_WD_W'(1)) begin
                        next_st.idleCnt = '0;
                        if (sdaF) begin
                            next_st.busFree = 1'b1;
                        end else begin
                            next_st.wdState  = ICT_WD_RECOVER;
                            next_st.halfCnt  = '0;
                            next_st.pulseCnt = '0;
                            next_st.recEdges = 4'h1;
                            next_st.sclOe    = 1'b1;
                        end
                    end else begin
                        next_st.idleCnt = st.idleCnt + `ICT_WD_W'(1);
                    end
                end
                ICT_WD_RECOVER: begin
                    if (st.halfCnt == `ICT_HALF_W'(`ICT_REC_HALF_CYC - 1)) begin
                        next_st.halfCnt = '0;
                        if (st.sclOe) begin
                            next_st.sclOe = 1'b0;
                        end else if (st.pulseCnt == `ICT_REC_PULSES - 4'h1) begin
                            next_st.wdState = ICT_WD_RUN;
                            next_st.idleCnt = '0;
                        end else begin
                            next_st.sclOe    = 1'b1;
                            next_st.pulseCnt = st.pulseCnt + 4'h1;
                            next_st.recEdges = st.recEdges + 4'h1;
                        end
                    end else begin
                        next_st.halfCnt = st.halfCnt + `ICT_HALF_W'(1);
                    end
                end
            endcase
        end
    end

    // core side state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.ctrl2   <= `ICT_CTRL2_RESET;
            st.timing  <= `ICT_TIMING_RESET;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
            st.wdState <= ICT_WD_RUN;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign regRdData  = st.rdData;
    assign slaveWrOut = slaveWrIn;
    assign sclOut     = 1'b0;
    assign sdaOut     = 1'b0;
    assign sclOe      = st.sclOe;
    assign sdaOe      = st.sdaOe;
    assign sclSample  = st.sclSample;
    assign sdaSample  = st.sdaSample;
    assign busFree    = st.busFree;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_recEnd;
        (st.wdState == ICT_WD_RECOVER) && !wdOff ##1 (st.wdState == ICT_WD_RUN);
    endsequence

    a_err_set: assert property (seqEvent |=> st.ctrl2[`ICT_C2_SEQERR])
        else $error("sequence error not flagged");
    a_err_clear: assert property (clrPulse && !seqEvent |=> !st.ctrl2[`ICT_C2_SEQERR])
        else $error("sequence error not cleared");
    a_err_sticky: assert property (st.ctrl2[`ICT_C2_SEQERR] && !clrPulse |=> st.ctrl2[`ICT_C2_SEQERR])
        else $error("sequence error dropped by itself");
    a_remote_lock: assert property (regWr && regWrRemote && st.ctrl2[`ICT_C2_LWBLOCK]
                                    && !seqEvent |=> $stable(st.ctrl2) && $stable(st.timing))
        else $error("remote write passed the lock");
    a_slave_pass: assert property (slaveWrIn |-> slaveWrOut)
        else $error("remote slave write blocked");
    a_hold_tap: assert property ((hold == 3'h1) && ($past(hold, 11) == 3'h1)
                                 |-> st.sdaSample == $past(sdaF, 11))
        else $error("sda hold delay wrong");
    a_sda_delay: assert property ($changed(st.sdaOe) |-> $past(st.dlyCnt) == $past(dlyTarget) - 7'h01)
        else $error("sda output delay wrong");
    a_wd_expire: assert property ((st.wdState == ICT_WD_RUN) && !wdOff && !activity && !st.busFree
                                  && (st.idleCnt == wdLimit - 28'h1)
                                  |=> st.busFree || (st.wdState == ICT_WD_RECOVER))
        else $error("watchdog did not expire");
    a_nine_pulses: assert property (s_recEnd |-> $past(st.recEdges) == `ICT_REC_PULSES)
        else $error("recovery pulse count wrong");
    a_wd_stop: assert property (wdOff |=> (st.idleCnt == '0) && !st.sclOe)
        else $error("watchdog ran while disabled");
endmodule

// ===== design/ict_map.svh
// constants for the i2c control channel tuning block
// assumes a 200 MHz core clock; included by ict_pkg and the testbench
// Notes on behaviour
// - sda sampling held after scl, 50 ns steps
// - reject scl/sda pulses up to depth times 10 ns
// - bit 7 flags forward channel sequence error
// - writing bit 6 high clears the error flag
// - sda output delay 350 to 500 ns
// - lock blocks remote writes to own registers
// - remote access to local slaves still passes
// - watchdog expires 50 us fast, 1 s slow
// - stuck low sda: nine scl pulses free bus
// - bit 0 stops the bus watchdog
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets, reset values, write masks
`define ICT_REG_TIMING    8'h21
`define ICT_REG_CTRL2     8'h22
`define ICT_TIMING_RESET  8'h00
`define ICT_CTRL2_RESET   8'h00
`define ICT_TIMING_WMASK  8'h7f
`define ICT_CTRL2_WMASK   8'h5f
`define ICT_RD_UNMAPPED   8'h00

////////////////////////////////////////////////////////////////////////////////
// field positions
`define ICT_C2_SEQERR     7
`define ICT_C2_CLEAR      6
`define ICT_C2_DLY_HI     4
`define ICT_C2_DLY_LO     3
`define ICT_C2_LWBLOCK    2
`define ICT_C2_SPEEDUP    1
`define ICT_C2_WDOFF      0
`define ICT_TM_HOLD_HI    6
`define ICT_TM_HOLD_LO    4
`define ICT_TM_FILT_HI    3
`define ICT_TM_FILT_LO    0

////////////////////////////////////////////////////////////////////////////////
// times in ns and derived cycle counts
`define ICT_CLK_NS          5
`define ICT_CYC_CEIL(ns)    (((ns) + `ICT_CLK_NS - 1) / `ICT_CLK_NS)
`define ICT_CYC_FLOOR(ns)   ((ns) / `ICT_CLK_NS)
`define ICT_FILT_STEP_NS    10
`define ICT_HOLD_STEP_NS    50
`define ICT_SDA_BASE_NS     350
`define ICT_SDA_STEP_NS     50
`define ICT_WD_FAST_NS      50000
`define ICT_WD_SLOW_NS      1000000000
`define ICT_REC_HALF_NS     2500
`define ICT_FILT_STEP_CYC   `ICT_CYC_CEIL(`ICT_FILT_STEP_NS)
`define ICT_HOLD_STEP_CYC   `ICT_CYC_CEIL(`ICT_HOLD_STEP_NS)
`define ICT_SDA_BASE_CYC    `ICT_CYC_CEIL(`ICT_SDA_BASE_NS)
`define ICT_SDA_STEP_CYC    `ICT_CYC_CEIL(`ICT_SDA_STEP_NS)
`define ICT_WD_FAST_CYC     `ICT_CYC_FLOOR(`ICT_WD_FAST_NS)
`define ICT_WD_SLOW_CYC     `ICT_CYC_FLOOR(`ICT_WD_SLOW_NS)
`define ICT_REC_HALF_CYC    `ICT_CYC_FLOOR(`ICT_REC_HALF_NS)
`define ICT_REC_PULSES      4'h9

////////////////////////////////////////////////////////////////////////////////
// storage widths
`define ICT_HOLD_MAX        7
`define ICT_LINE_W          (`ICT_HOLD_MAX * `ICT_HOLD_STEP_CYC)
`define ICT_WD_W            28
`define ICT_DLY_W           7
`define ICT_HALF_W          12
`define ICT_FCNT_W          5

`endif

// ===== design/ict_pkg.sv
// types shared by the tuning block modules
// assumes ict_map.svh is on the include path
package ict_pkg;
    `include "ict_map.svh"

    // watchdog states
    typedef enum logic [0:0] {ICT_WD_RUN, ICT_WD_RECOVER} ict_wd_e;

    // glitch filter state
    typedef struct packed {
        logic                   s1;
        logic                   s2;
        logic                   s3;
        logic                   level;
        logic [`ICT_FCNT_W-1:0] cnt;
    } ict_filt_s;

    // link side state
    typedef struct packed {
        logic tgl;
    } ict_link_s;

    // core side state
    typedef struct packed {
        logic [7:0]             ctrl2;
        logic [7:0]             timing;
        logic [7:0]             rdData;
        logic                   tgS1;
        logic                   tgS2;
        logic                   tgS3;
        logic                   tgSeen;
        logic [`ICT_LINE_W-1:0] holdLine;
        logic                   sclSample;
        logic                   sdaSample;
        logic                   sdaOe;
        logic [`ICT_DLY_W-1:0]  dlyCnt;
        ict_wd_e                wdState;
        logic [`ICT_WD_W-1:0]   idleCnt;
        logic                   sclPrev;
        logic                   sdaPrev;
        logic                   busFree;
        logic [`ICT_HALF_W-1:0] halfCnt;
        logic [3:0]             pulseCnt;
        logic [3:0]             recEdges;
        logic                   sclOe;
    } ict_main_s;
endpackage

// ===== design/ict_glitch_filter.sv
// glitch filter for one i2c input pin
// assumes an asynchronous pin; depth comes from a core clock register
module ict_glitch_filter
    import ict_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // control
    input  wire logic [3:0] depth,
    // pin and filtered level
    input  wire logic       pinIn,
    output logic            level
);
    ict_filt_s st;
    ict_filt_s next_st;
    logic [`ICT_FCNT_W-1:0] limit;
    logic                   agreed;

    ////////////////////////////////////////////////////////////////////////////
    // sync, then switch only after the input has differed past the limit
    always_comb begin
        next_st = st;
        limit   = `ICT_FCNT_W'(depth * `ICT_FILT_STEP_CYC);
        agreed  = (st.s2 == st.s3) ? st.s3 : st.level;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (agreed == st.level) begin
            next_st.cnt = '0;
        end else if (st.cnt >= limit) begin
            next_st.level = agreed;
            next_st.cnt   = '0;
        end else begin
            next_st.cnt = st.cnt + `ICT_FCNT_W'(1);
        end
    end

    // state register, idle bus reads high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, cnt: '0};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_filter_width: assert property ($changed(st.level) |-> $past(st.cnt) >= $past(limit))
        else $error("filtered level changed before filter width");
endmodule

// ===== verif/ict_far_end.sv
// far side model: remote serializer event source and pulled-up i2c lines
// assumes the bench toggles errTgl once per wanted sequence error
module ict_far_end (
    // link side
    input  wire logic linkClk,
    input  wire logic rst_n,
    input  wire logic errTgl,
    output logic      seqErrLink,
    // i2c lines, open drain with pull-ups
    input  wire logic sclOe,
    input  wire logic sdaOe,
    input  wire logic sclHold,
    input  wire logic sdaHold,
    output logic      sclLine,
    output logic      sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic errSeen;
    ////////////////////////////////////////////////////////////////////////////
    // one link cycle pulse per toggle, launched just after a link edge
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            errSeen    <= 1'b0;
            seqErrLink <= 1'b0;
        end else begin
            errSeen    <= errTgl;
            seqErrLink <= errTgl ^ errSeen;
        end
    end
    // wired-and of every pull-down, pull-up otherwise
    assign sclLine = !(sclOe || sclHold);
    assign sdaLine = !(sdaOe || sdaHold);
endmodule

// ===== verif/testbench.sv
// self-checking bench for the i2c port tuning block
// assumes ict_pkg compiled first and ict_map.svh on the include path
`include "ict_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WDF = 300;
    localparam int WDS = 2000;
    logic       clock, rst_n, linkClk, regWr, regWrRemote, regRd, seqErrLink, slaveWrIn, slaveWrOut;
    logic       sclOe, sdaOe, sdaLowReq, sclSample, sdaSample, busFree, sclLine, sdaLine;
    logic       sclHold, sdaHold, errTgl, fell, prevOe;
    logic [7:0] regAddr, regWrData, regRdData, d, e;
    logic [3:0] dep;
    int         n_mismatch, comparisons, cnt, c0;
    ////////////////////////////////////////////////////////////////////////////
    // clocks: core 5 ns, link 125 ns with an unrelated phase
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        linkClk = 1'b0;
        #17.3;
        forever #62.5 linkClk = ~linkClk;
    end
    ict_i2c_tuning #(.WD_FAST_CYC(28'(WDF)), .WD_SLOW_CYC(28'(WDS))) ict_i2c_tuning_i (
        .clock(clock), .rst_n(rst_n), .linkClk(linkClk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regWrRemote(regWrRemote), .regRd(regRd), .regRdData(regRdData),
        .seqErrLink(seqErrLink), .slaveWrIn(slaveWrIn), .slaveWrOut(slaveWrOut), .sclIn(sclLine),
        .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .sdaLowReq(sdaLowReq),
        .sclSample(sclSample), .sdaSample(sdaSample), .busFree(busFree));
    ict_far_end ict_far_end_i (
        .linkClk(linkClk), .rst_n(rst_n), .errTgl(errTgl), .seqErrLink(seqErrLink), .sclOe(sclOe),
        .sdaOe(sdaOe), .sclHold(sclHold), .sdaHold(sdaHold), .sclLine(sclLine), .sdaLine(sdaLine));
    ////////////////////////////////////////////////////////////////////////////
    // compare, count, report
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // register port cycles, entered at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic remote);
        regAddr     = a;
        regWrData   = v;
        regWrRemote = remote;
        regWr       = 1'b1;
        @(negedge clock);
        regWr = 1'b0;
        @(negedge clock); // idle cycle between two write strobes
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        regAddr = a;
        regRd   = 1'b1;
        @(negedge clock);
        regRd = 1'b0;
        @(negedge clock);
        check(what, exp, regRdData);
    endtask
    // pull one line low for len cycles, note any fall of its filtered level
    task automatic glitch(input logic onSda, input int len);
        fell = 1'b0;
        {sdaHold, sclHold} = onSda ? 2'b10 : 2'b01;
        repeat (len + 45) begin
            @(negedge clock);
            fell = fell | !(onSda ? sdaSample : sclSample);
            len--;
            if (len == 0) {sdaHold, sclHold} = 2'b00;
        end
    endtask
    // cycles from sda line fall to sampled sda fall
    task automatic sda_lag(input logic [2:0] h, output int n);
        wr(8'h21, {1'b0, h, 4'h0}, 1'b0);
        cyc(5);
        sdaHold = 1'b1;
        n = 0;
        while (sdaSample !== 1'b0 && n < 200) begin
            @(negedge clock);
            n++;
        end
        sdaHold = 1'b0;
        cyc(100);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    // main sequence
    initial begin
        {regAddr, regWrData, regWr, regWrRemote, regRd, slaveWrIn, sdaLowReq, sclHold, sdaHold, errTgl} = '0;
        n_mismatch  = 0;
        comparisons = 0;
        rst_n       = 1'b1;
        #1;
        rst_n       = 1'b0; // clean falling edge resets both clock domains
        void'($urandom(32'h48297eb9));
        cyc(8);
        rst_n = 1'b1;
        cyc(8);
        rchk(8'h22, 8'h00, "ctrl2 reset");
        rchk(8'h21, 8'h00, "timing reset");
        rchk(8'h30, 8'h00, "unmapped read");
        // random traffic, bus watchdog kept stopped
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(8'h21, d, 1'b0);
            rchk(8'h21, d & 8'h7f, "timing rw");
            d = 8'($urandom) | 8'h01;
            wr(8'h22, d, 1'b0);
            rchk(8'h22, d & 8'h5f, "ctrl2 rw");
        end
        // sequence error: set, held across other writes, cleared
        wr(8'h22, 8'h01, 1'b0);
        errTgl = ~errTgl;
        cyc(80);
        rchk(8'h22, 8'h81, "seq error set");
        wr(8'h22, 8'h1d, 1'b0);
        rchk(8'h22, 8'h9d, "seq error held");
        wr(8'h22, 8'h41, 1'b0);
        rchk(8'h22, 8'h41, "seq error cleared");
        // remote write lock
        wr(8'h21, 8'h11, 1'b0);
        wr(8'h22, 8'h05, 1'b0);
        wr(8'h21, 8'h6a, 1'b1);
        wr(8'h22, 8'h01, 1'b1);
        rchk(8'h21, 8'h11, "locked remote timing");
        rchk(8'h22, 8'h05, "locked remote ctrl2");
        slaveWrIn = 1'b1;
        cyc(1);
        check("slave pass", 8'h01, {7'h0, slaveWrOut});
        slaveWrIn = 1'b0;
        wr(8'h22, 8'h01, 1'b0);
        wr(8'h21, 8'h6a, 1'b1);
        rchk(8'h21, 8'h6a, "unlocked remote write");
        // glitch filter on both lines: longest rejected, then accepted
        for (int k = 0; k < 6; k++) begin
            dep = (k < 2) ? 4'h1 : (k < 4) ? 4'hf : 4'(1 + $urandom % 14);
            wr(8'h21, {4'h0, dep}, 1'b0);
            cyc(5);
            glitch(k[0], dep * `ICT_FILT_STEP_CYC);
            check("glitch rejected", 8'h00, {7'h0, fell});
            glitch(k[0], dep * `ICT_FILT_STEP_CYC + 4);
            check("pulse accepted", 8'h01, {7'h0, fell});
        end
        // sda input hold in 50 ns steps
        sda_lag(3'h0, c0);
        for (int h = 1; h < 8; h += 3) begin
            sda_lag(3'(h), cnt);
            check("sda hold lag", 8'(h * `ICT_HOLD_STEP_CYC), 8'(cnt - c0));
        end
        // sda output delay for every code, plus a request that reverts early
        for (int c = 0; c < 4; c++) begin
            wr(8'h22, {3'b000, 2'(c), 3'b001}, 1'b0);
            e = 8'(`ICT_SDA_BASE_CYC + c * `ICT_SDA_STEP_CYC);
            sdaLowReq = 1'b1;
            cnt = 0;
            while (sdaOe !== 1'b1 && cnt < 300) begin
                @(negedge clock);
                cnt++;
            end
            check("sda out delay", e, (cnt >= e && cnt <= e + 2) ? e : 8'(cnt));
            sdaLowReq = 1'b0;
            cyc(120);
        end
        sdaLowReq = 1'b1;
        cyc(40);
        sdaLowReq = 1'b0;
        cyc(100);
        check("short request dropped", 8'h00, {7'h0, sdaOe});
        // bus watchdog: fast, stopped, slow
        wr(8'h22, 8'h03, 1'b0);
        wr(8'h22, 8'h02, 1'b0);
        cyc(WDF - 20);
        check("wd fast early", 8'h00, {7'h0, busFree});
        cyc(40);
        check("wd fast expiry", 8'h01, {7'h0, busFree});
        wr(8'h22, 8'h03, 1'b0);
        cyc(WDF + 50);
        check("wd stopped", 8'h00, {7'h0, busFree});
        wr(8'h22, 8'h00, 1'b0);
        cyc(WDS - 40);
        check("wd slow early", 8'h00, {7'h0, busFree});
        cyc(80);
        check("wd slow expiry", 8'h01, {7'h0, busFree});
        // stuck sda: nine scl pulses, then stop mid recovery
        sdaHold = 1'b1;
        wr(8'h22, 8'h02, 1'b0);
        cnt    = 0;
        prevOe = 1'b0;
        repeat (WDF + 18 * `ICT_REC_HALF_CYC + 150) begin
            @(negedge clock);
            if (sclOe === 1'b1 && prevOe !== 1'b1) cnt++;
            prevOe = sclOe;
        end
        check("recovery pulses", 8'd9, 8'(cnt));
        cyc(WDF + 600);
        wr(8'h22, 8'h03, 1'b0);
        cyc(5);
        check("recovery aborted", 8'h00, {7'h0, sclOe});
        sdaHold = 1'b0;
        cyc(20);
        end_sim();
    end
endmodule
